/* File: rtl/barrier_pkg.sv */
// What this block does
// [RULE1] write barrier waits in store queue until retired and older stores writable
// [RULE2] then freeze store-queue writable pointer and notify the cache/system side
// [RULE3] close the open I/O write buffer merge entry before barrier handling
// [RULE4] stall miss and I/O write processing while a barrier is serviced
// [RULE5] internal mode: mark youngest probe entry when counter steps one to zero
// [RULE6] barrier completes only after probe response for the marked entry
// [RULE7] external mode: issue barrier command after stalling miss and I/O writes
// [RULE8] external mode: on barrier-done response, acknowledge and mark youngest probe
// [RULE9] system answers every barrier command with a barrier-done response
// [RULE10] queued TLB entry write after page-table load sets scoreboard bits 4, 0
// [RULE11] data TLB entry write issue starts injected barrier processing
// [RULE12] scoreboard bit 0 stays set while the injected barrier is outstanding
// [RULE13] after injected barrier completes, scoreboard bit 0 is cleared
// [RULE14] instruction TLB fill stalls fetch until probe queue has drained
// [RULE15] instruction fill barrier end resumes prefetch and clears bit 0
// [RULE16] TLB fill barrier enable clear skips barrier injection on fills
// [RULE17] external barrier enable selects system command or internal counting
// [RULE18] uncommitted counter decrements on each commit bit from the system
// [RULE19] counter at 15 stalls miss and I/O writes; probes continue
// [RULE20] on completion release writable pointer and resume miss and I/O writes
package barrier_pkg;
    // register map
    localparam logic [7:0]  CTRL_ADDR    = 8'h00;
    localparam logic [7:0]  STATUS_ADDR  = 8'h04;
    localparam int          CTRL_EXT_BIT = 0;
    localparam int          CTRL_TLB_BIT = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h2;
    // status layout: count [3:0], state [6:4], bit0 [8], bit4 [9]
    localparam int          ST_CNT_LSB   = 0;
    localparam int          ST_FSM_LSB   = 4;
    localparam int          ST_SB0_BIT   = 8;
    localparam int          ST_SB4_BIT   = 9;
    localparam logic [3:0]  COUNT_MAX    = 4'hf;
    localparam logic [3:0]  COUNT_ONE    = 4'h1;
    localparam logic [3:0]  COUNT_ZERO   = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_CLOSE  = 3'h1,
        ST_COUNT  = 3'h3,
        ST_CMD    = 3'h5,
        ST_DONE   = 3'h7,
        ST_RESP   = 3'h2,
        ST_FINISH = 3'h6
    } state_type;

    typedef enum logic [1:0] {
        SRC_WMB  = 2'h0,
        SRC_DTLB = 2'h1,
        SRC_ITLB = 2'h2
    } source_type;
endpackage

/* File: rtl/memory_barrier_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module memory_barrier_sequencer (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // store queue
    input  wire logic        i_wbar_in_sq,
    input  wire logic        i_wbar_retired,
    input  wire logic        i_older_stores_writable,
    output logic             o_sq_wr_ptr_freeze,
    output logic             o_wbar_done,
    // write buffer and miss file
    output logic             o_io_write_buffer_close_merge,
    output logic             o_maf_io_write_buffer_stall,
    // system port
    input  wire logic        i_txn_issue,
    input  wire logic        i_commit,
    input  wire logic        i_barrier_done_resp,
    output logic             o_barrier_cmd,
    output logic             o_barrier_ack,
    // probe queue
    input  wire logic        i_marked_probe_resp_sent,
    input  wire logic        i_probe_queue_empty,
    output logic             o_mark_probe,
    // fetch and issue
    input  wire logic        i_tlb_write_queued,
    input  wire logic        i_dtlb_write_issued,
    input  wire logic        i_itlb_pte_load_done,
    output logic             o_sb_bit0,
    output logic             o_sb_bit4,
    output logic             o_fetch_stall,
    output logic             o_resume_prefetch
);
    // ****************************************
    // register bus
    // ****************************************
    logic [1:0]  ctrl_q, ctrl_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [3:0]  count_q, count_d;
    logic        sb0_q, sb0_d, sb4_q, sb4_d;
    barrier_pkg::state_type  state_q, state_d;
    barrier_pkg::source_type src_q, src_d;
    logic        mode_q, mode_d;
    logic        resp_q, resp_d;
    logic        pend_d_q, pend_d_d, pend_i_q, pend_i_d;
    logic        ext_en, tlb_en, busy, wmb_go, skip;

    assign ext_en = ctrl_q[barrier_pkg::CTRL_EXT_BIT];
    assign tlb_en = ctrl_q[barrier_pkg::CTRL_TLB_BIT];

    // single-wait ack; unmapped reads return zero, writes dropped
    always_comb begin
        ctrl_d = ctrl_q;
        rdat_d = 32'h0;
        ack_d  = i_wb_cyc & i_wb_stb & ~ack_q;
        if (ack_d && i_wb_we && i_wb_sel[0] &&
            i_wb_adr == barrier_pkg::CTRL_ADDR) begin
            ctrl_d = i_wb_dat[1:0];
        end
        if (ack_d && !i_wb_we) begin
            if (i_wb_adr == barrier_pkg::CTRL_ADDR) begin
                rdat_d = {30'h0, ctrl_q};
            end else if (i_wb_adr == barrier_pkg::STATUS_ADDR) begin
                rdat_d[barrier_pkg::ST_CNT_LSB +: 4] = count_q;
                rdat_d[barrier_pkg::ST_FSM_LSB +: 3] = state_q;
                rdat_d[barrier_pkg::ST_SB0_BIT]      = sb0_q;
                rdat_d[barrier_pkg::ST_SB4_BIT]      = sb4_q;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_q <= barrier_pkg::CTRL_RESET;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            ctrl_q <= ctrl_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // ****************************************
    // uncommitted transaction counter
    // ****************************************
    // saturates both ways; a commit and an issue together cancel
    always_comb begin
        count_d = count_q;
        // [RULE18] commit decrements
        if (i_commit && !i_txn_issue && count_q != barrier_pkg::COUNT_ZERO) begin
            count_d = count_q - 4'h1;
        end else if (i_txn_issue && !i_commit &&
                     count_q != barrier_pkg::COUNT_MAX) begin
            count_d = count_q + 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count_q <= 4'h0;
        end else begin
            count_q <= count_d;
        end
    end

    // ****************************************
    // barrier sequencer
    // ****************************************
    // [RULE1] retired and older stores writable
    assign wmb_go = i_wbar_in_sq & i_wbar_retired & i_older_stores_writable;
    assign busy   = state_q != barrier_pkg::ST_IDLE &&
                    state_q != barrier_pkg::ST_FINISH;
    // [RULE16] fills with injection disabled skip the barrier
    assign skip   = i_dtlb_write_issued & ~tlb_en;

    always_comb begin
        state_d            = state_q;
        src_d              = src_q;
        mode_d             = mode_q;
        resp_d             = resp_q;
        pend_d_d           = pend_d_q | (i_dtlb_write_issued & tlb_en);
        pend_i_d           = pend_i_q | (i_itlb_pte_load_done & tlb_en);
        o_io_write_buffer_close_merge = 1'b0;
        o_barrier_cmd      = 1'b0;
        o_barrier_ack      = 1'b0;
        o_mark_probe       = 1'b0;
        o_wbar_done        = 1'b0;
        o_resume_prefetch  = 1'b0;
        case (state_q)
            barrier_pkg::ST_IDLE: begin
                resp_d = 1'b0;
                // [RULE17] mode captured per barrier
                mode_d = ext_en;
                // [RULE11] fills take priority over store barriers
                if (pend_d_q) begin
                    pend_d_d = 1'b0;
                    src_d    = barrier_pkg::SRC_DTLB;
                    state_d  = barrier_pkg::ST_CLOSE;
                end else if (pend_i_q) begin
                    pend_i_d = 1'b0;
                    src_d    = barrier_pkg::SRC_ITLB;
                    state_d  = barrier_pkg::ST_CLOSE;
                end else if (wmb_go) begin
                    src_d    = barrier_pkg::SRC_WMB;
                    state_d  = barrier_pkg::ST_CLOSE;
                end
            end
            barrier_pkg::ST_CLOSE: begin
                // [RULE3] close merge entry first
                o_io_write_buffer_close_merge = 1'b1;
                state_d = mode_q ? barrier_pkg::ST_CMD : barrier_pkg::ST_COUNT;
            end
            barrier_pkg::ST_COUNT: begin
                // [RULE5] step one to zero, or already drained
                if (count_q == barrier_pkg::COUNT_ZERO ||
                    (count_q == barrier_pkg::COUNT_ONE &&
                     count_d == barrier_pkg::COUNT_ZERO)) begin
                    o_mark_probe = 1'b1;
                    state_d      = barrier_pkg::ST_RESP;
                end
            end
            barrier_pkg::ST_CMD: begin
                // [RULE7] command after the stall is up
                o_barrier_cmd = 1'b1;
                state_d       = barrier_pkg::ST_DONE;
            end
            barrier_pkg::ST_DONE: begin
                // [RULE8] ack and mark on done response
                if (i_barrier_done_resp) begin
                    o_barrier_ack = 1'b1;
                    o_mark_probe  = 1'b1;
                    state_d       = barrier_pkg::ST_RESP;
                end
            end
            barrier_pkg::ST_RESP: begin
                // [RULE6] wait for the marked probe response
                resp_d = resp_q | i_marked_probe_resp_sent;
                // [RULE14] instruction fills also wait for drain
                if (resp_d && (src_q != barrier_pkg::SRC_ITLB ||
                               i_probe_queue_empty)) begin
                    state_d = barrier_pkg::ST_FINISH;
                end
            end
            barrier_pkg::ST_FINISH: begin
                o_wbar_done       = src_q == barrier_pkg::SRC_WMB;
                // [RULE15] resume prefetch at end
                o_resume_prefetch = src_q == barrier_pkg::SRC_ITLB;
                state_d           = barrier_pkg::ST_IDLE;
            end
            default: begin
                state_d = barrier_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q  <= barrier_pkg::ST_IDLE;
            src_q    <= barrier_pkg::SRC_WMB;
            mode_q   <= 1'b0;
            resp_q   <= 1'b0;
            pend_d_q <= 1'b0;
            pend_i_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            src_q    <= src_d;
            mode_q   <= mode_d;
            resp_q   <= resp_d;
            pend_d_q <= pend_d_d;
            pend_i_q <= pend_i_d;
        end
    end

    // [RULE2] [RULE20] pointer frozen only while busy
    assign o_sq_wr_ptr_freeze = busy && src_q == barrier_pkg::SRC_WMB;
    // [RULE4] [RULE19] stall while busy or saturated
    assign o_maf_io_write_buffer_stall   = busy || count_q == barrier_pkg::COUNT_MAX;
    // [RULE14] fetch held during instruction fill
    // held from the load completing, not only once the sequencer starts
    assign o_fetch_stall      = (busy && src_q == barrier_pkg::SRC_ITLB) ||
                                pend_i_q ||
                                (i_itlb_pte_load_done && tlb_en);

    // ****************************************
    // scoreboard bits
    // ****************************************
    // a new queued write wins over a same-cycle clear
    always_comb begin
        sb4_d = sb4_q;
        sb0_d = sb0_q;
        if (i_dtlb_write_issued || i_itlb_pte_load_done) begin
            sb4_d = 1'b0;
        end
        // [RULE13] clear bit 0 at end, or at once when skipped
        if ((state_q == barrier_pkg::ST_FINISH &&
             src_q != barrier_pkg::SRC_WMB) || skip) begin
            sb0_d = 1'b0;
        end
        // [RULE10] set both bits on queue
        if (i_tlb_write_queued) begin
            sb4_d = 1'b1;
            sb0_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sb4_q <= 1'b0;
            sb0_q <= 1'b0;
        end else begin
            sb4_q <= sb4_d;
            sb0_q <= sb0_d;
        end
    end

    // [RULE12] bit 0 drives the issue block
    assign o_sb_bit0 = sb0_q;
    assign o_sb_bit4 = sb4_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    AST_FREEZE: assert property ( // [RULE2]
        state_q == barrier_pkg::ST_IDLE && wmb_go && !pend_d_q && !pend_i_q
        |=> o_sq_wr_ptr_freeze ##1 o_maf_io_write_buffer_stall)
        else $error("writable pointer not frozen");
    AST_CLOSE_FIRST: assert property ( // [RULE3]
        $rose(busy) |-> o_io_write_buffer_close_merge && o_maf_io_write_buffer_stall)
        else $error("merge entry not closed on start");
    AST_CMD_AFTER: assert property ( // [RULE7]
        o_barrier_cmd |-> mode_q && $past(o_io_write_buffer_close_merge) && o_maf_io_write_buffer_stall)
        else $error("barrier command out of order");
    AST_MARK_STEP: assert property ( // [RULE5]
        state_q == barrier_pkg::ST_COUNT && count_q == 4'h1 && i_commit &&
        !i_txn_issue |-> o_mark_probe ##1 state_q == barrier_pkg::ST_RESP)
        else $error("no mark on count step to zero");
    AST_ACK_MARK: assert property ( // [RULE8]
        state_q == barrier_pkg::ST_DONE && i_barrier_done_resp
        |-> o_barrier_ack && o_mark_probe)
        else $error("done response not acknowledged");
    AST_DONE_AFTER_RESP: assert property ( // [RULE6]
        o_wbar_done |-> resp_q)
        else $error("barrier done before probe response");
    AST_RELEASE: assert property ( // [RULE20]
        o_wbar_done |-> !o_sq_wr_ptr_freeze ##1 !o_sq_wr_ptr_freeze)
        else $error("pointer not released");
    AST_SATURATE: assert property ( // [RULE19]
        count_q == 4'hf |-> o_maf_io_write_buffer_stall)
        else $error("no stall at saturation");
    AST_DECREMENT: assert property ( // [RULE18]
        i_commit && !i_txn_issue && count_q != 4'h0
        |=> count_q == $past(count_q) - 4'h1)
        else $error("commit did not decrement");
    AST_SB_SET: assert property ( // [RULE10]
        i_tlb_write_queued |=> sb4_q && sb0_q)
        else $error("scoreboard bits not set");
    AST_SB_HOLD: assert property ( // [RULE12]
        sb0_q && busy && src_q != barrier_pkg::SRC_WMB && !skip |=> sb0_q)
        else $error("bit 0 dropped during barrier");
    AST_SB_SKIP: assert property ( // [RULE16]
        skip && !i_tlb_write_queued |=> !sb0_q)
        else $error("disabled fill not skipped");
    AST_FETCH: assert property ( // [RULE14]
        o_resume_prefetch |-> $past(i_probe_queue_empty) && $past(o_fetch_stall))
        else $error("prefetch resumed before drain");

    CV_INTERNAL: cover property (
        state_q == barrier_pkg::ST_COUNT ##1 state_q == barrier_pkg::ST_RESP);
    CV_EXTERNAL: cover property (o_barrier_cmd ##[1:20] o_barrier_ack);
    CV_ITLB: cover property (o_resume_prefetch);
    CV_SAT: cover property (count_q == 4'hf && i_commit);
endmodule
`default_nettype wire

/* File: test/system_port_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// far side of the system port
// ****************************************
module system_port_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // from the sequencer, and the issue strobe it also sees
    input  wire logic       i_barrier_cmd,
    input  wire logic       i_mark_probe,
    input  wire logic       i_txn_issue,
    // bench knobs
    input  wire logic       i_commit_en,
    input  wire logic [3:0] i_lat,
    // answers
    output logic            o_done_resp,
    output logic            o_commit,
    output logic            o_probe_resp
);
    int   dcnt, pcnt, ccnt, pend;
    logic dwait, pwait;

    initial {o_done_resp, o_commit, o_probe_resp} = 3'h0;

    // every answer comes i_lat cycles late, so slow systems get exercised
    always @(posedge i_clk) begin
        o_done_resp <= 1'b0;
        o_commit <= 1'b0;
        o_probe_resp <= 1'b0;
        if (i_srst) begin
            {dwait, pwait} = 2'h0;
            pend = 0;
            ccnt = 0;
        end else begin
            if (i_txn_issue) pend++;
            if (i_barrier_cmd) begin
                dwait = 1'b1;
                dcnt = i_lat;
            end else if (dwait && dcnt == 0) begin
                o_done_resp <= 1'b1;
                dwait = 1'b0;
            end else if (dwait) dcnt--;
            if (i_mark_probe) begin
                pwait = 1'b1;
                pcnt = i_lat;
            end else if (pwait && pcnt == 0) begin
                o_probe_resp <= 1'b1;
                pwait = 1'b0;
            end else if (pwait) pcnt--;
            if (i_commit_en && pend > 0 && ccnt >= i_lat) begin
                o_commit <= 1'b1;
                pend--;
                ccnt = 0;
            end else if (i_commit_en && pend > 0) ccnt++;
        end
    end
endmodule
`default_nettype wire

/* File: test/memory_barrier_sequencer_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t got %0h want %0h", $time, a, b); end end
`define PULSE(s) begin s <= 1'b1; @(posedge clk); s <= 1'b0; end
`define WAITF(c) begin for (n = 0; n < 400 && !(c); n++) @(posedge clk); \
    if (!(c)) begin bad_count++; $display("BAD %0t wait ran out", $time); end end
module memory_barrier_sequencer_test;
    logic        clk, srst, cyc, stb, we, ack, in_sq, retired, wrable;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, r;
    logic        freeze, wdone, close_m, stall, txn, commit, dresp, cmd;
    logic        back, presp, pqe, mark, tq, dti, ipl, sb0, sb4, fst;
    logic        resume, cen, got_p;
    logic [3:0]  lat;
    logic [63:0] e;
    int          bad_count, check_count, n, cmds, x, cl;
    logic [63:0] exp_q[$];
    int          exp_cmd[$];

    memory_barrier_sequencer DUT (
        .i_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_wbar_in_sq(in_sq),
        .i_wbar_retired(retired), .i_older_stores_writable(wrable),
        .o_sq_wr_ptr_freeze(freeze), .o_wbar_done(wdone),
        .o_io_write_buffer_close_merge(close_m), .o_maf_io_write_buffer_stall(stall),
        .i_txn_issue(txn), .i_commit(commit), .i_barrier_done_resp(dresp),
        .o_barrier_cmd(cmd), .o_barrier_ack(back),
        .i_marked_probe_resp_sent(presp), .i_probe_queue_empty(pqe),
        .o_mark_probe(mark), .i_tlb_write_queued(tq),
        .i_dtlb_write_issued(dti), .i_itlb_pte_load_done(ipl),
        .o_sb_bit0(sb0), .o_sb_bit4(sb4), .o_fetch_stall(fst),
        .o_resume_prefetch(resume));
    system_port_model PEER (
        .i_clk(clk), .i_srst(srst), .i_barrier_cmd(cmd), .i_mark_probe(mark),
        .i_txn_issue(txn), .i_commit_en(cen), .i_lat(lat),
        .o_done_resp(dresp), .o_commit(commit), .o_probe_resp(presp));

    // ****************************************
    // clock, bus cycle and closing
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // one classic cycle; a read notes the masked value it expects
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m);
        int k;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        if (!w) exp_q.push_back({m, d & m});
        for (k = 0; k < 64 && ack !== 1'b1; k++) @(posedge clk);
        // a bus that never answers is a failure, not a silent skip
        if (ack !== 1'b1) begin
            bad_count++;
            $display("BAD %0t no bus ack", $time);
        end
        {cyc, stb} <= 2'b00;
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // write barrier; retire is held back first so an early start shows
    task automatic write_barrier_instr(input logic ext);
        wb(1'b1, barrier_pkg::CTRL_ADDR, {30'h0, 1'b1, ext}, 32'h0);
        exp_cmd.push_back(int'(ext));
        cmds = 0;
        got_p = 1'b0;
        {in_sq, retired, wrable} <= 3'b101;
        repeat (5) @(posedge clk);
        `CHK(freeze, 1'b0)
        retired <= 1'b1;
        `WAITF(freeze === 1'b1)
        `CHK(close_m, 1'b1)
        `CHK(stall, 1'b1)
        `WAITF(wdone === 1'b1)
        {in_sq, retired, wrable} <= 3'b000;
        @(posedge clk);
        `CHK({freeze, stall}, 2'b00)
    endtask

    // ****************************************
    // monitor: results against queued notes
    // ****************************************
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK(rdat & e[63:32], e[31:0])
        end
        if (cmd === 1'b1) cmds++;
        if (presp === 1'b1) got_p = 1'b1;
        if (back === 1'b1) `CHK(mark, 1'b1)
        if (wdone === 1'b1 && exp_cmd.size() > 0) begin
            x = exp_cmd.pop_front();
            `CHK(got_p, 1'b1)
            `CHK(cmds, x)
        end
    end

    // a hang ends the run long after the few hundred cycles it needs
    initial begin
        #80000;
        bad_count++;
        $display("BAD %0t watchdog", $time);
        final_report;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {cyc, stb, we, adr, wdat} = '0;
        {in_sq, retired, wrable, txn, pqe, tq, dti, ipl} = 8'h08;
        {cen, got_p, lat, srst} = {2'b10, 4'h0, 1'b1};
        {bad_count, check_count, cmds} = {32'h0, 32'h0, 32'h0};
        void'($urandom(32'he14b));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        r = $urandom;
        wb(1'b0, 8'h00, {30'h0, barrier_pkg::CTRL_RESET}, 32'h3);
        wb(1'b1, barrier_pkg::CTRL_ADDR, r, 32'h0);
        wb(1'b0, barrier_pkg::CTRL_ADDR, r, 32'h3);
        wb(1'b1, 8'h08, $urandom, 32'h0);
        wb(1'b0, 8'h08, 32'h0, 32'hffffffff);
        wb(1'b0, barrier_pkg::STATUS_ADDR, 32'h0, 32'hffffffff);
        $display("test registers done");
        for (int m = 0; m < 2; m++) begin
            lat <= 4'($urandom_range(0, 5));
            write_barrier_instr(1'(m));
        end
        $display("test barrier modes done");
        // three open transactions drain by slow commits under a barrier
        {cen, txn, lat} <= {2'b01, 4'h8};
        repeat (3) @(posedge clk);
        txn <= 1'b0;
        wb(1'b0, barrier_pkg::STATUS_ADDR, 32'h3, 32'hf);
        cen <= 1'b1;
        write_barrier_instr(1'b0);
        wb(1'b0, barrier_pkg::STATUS_ADDR, 32'h0, 32'hf);
        $display("test commit count done");
        {cen, txn, lat} <= {2'b01, 4'h1};
        repeat (16) @(posedge clk);
        txn <= 1'b0;
        @(posedge clk);
        `CHK(stall, 1'b1)
        wb(1'b0, barrier_pkg::STATUS_ADDR, 32'hf, 32'hf);
        cen <= 1'b1;
        `WAITF(stall === 1'b0)
        `CHK(stall, 1'b0)
        $display("test saturation done");
        lat <= 4'h5;
        wb(1'b1, barrier_pkg::CTRL_ADDR, 32'h2, 32'h0);
        `PULSE(tq)
        wb(1'b0, barrier_pkg::STATUS_ADDR, 32'h300, 32'h300);
        `PULSE(dti)
        repeat (3) @(posedge clk);
        `CHK({sb0, stall}, 2'b11)
        `WAITF(sb0 === 1'b0)
        `CHK(sb0, 1'b0)
        $display("test data fill done");
        `PULSE(tq)
        pqe <= 1'b0;
        `PULSE(ipl)
        repeat (4) @(posedge clk);
        `CHK(fst, 1'b1)
        pqe <= 1'b1;
        `WAITF(resume === 1'b1)
        `CHK(resume, 1'b1)
        repeat (2) @(posedge clk);
        `CHK(sb0, 1'b0)
        $display("test instruction fill done");
        wb(1'b1, barrier_pkg::CTRL_ADDR, 32'h0, 32'h0);
        `PULSE(tq)
        `PULSE(dti)
        cl = 0;
        repeat (8) begin
            @(posedge clk);
            if (close_m === 1'b1) cl++;
        end
        `CHK(cl, 0)
        `CHK(sb0, 1'b0)
        $display("test fill without barrier done");
        final_report;
    end
endmodule
`default_nettype wire
